// file: rtl/ccs_top.sv
// Our own choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "ccs_map.svh"
module ccs_top import ccs_pkg::*; #(
  parameter int TICK_CYC = `CCS_TICK_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic scan_strobe,
  input wire logic [31:0] scan_value,
  input wire logic [31:0] scan_sample,
  input wire logic cal_start,
  input wire logic cal_abort,
  input wire logic cal_finish,
  input wire logic low_ref_sampled,
  input wire logic low_ref_good,
  input wire logic high_ref_sampled,
  input wire logic high_ref_good,
  input wire logic cal_data_applied,
  input wire logic conn_open,
  output logic rate_of_change_alarm,
  output logic calibration_fault_flag,
  output logic calibrating,
  output logic calibration_done_ok,
  output logic [14:0] scan_millisecond_stamp
);

  ccs_state_t s_q, s_d;
  logic [31:0] diff;
  logic [31:0] status;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Magnitude of the difference of two signed samples.
  function automatic logic [31:0] absdiff(input logic [31:0] a,
                                           input logic [31:0] b);
    logic signed [32:0] d;
    d = $signed({a[31], a}) - $signed({b[31], b});
    if (d[32]) begin
      d = -d;
    end
    absdiff = d[32] ? 32'hffffffff : d[31:0];
  endfunction

  assign diff = absdiff(s_q.sample, s_q.prev_sample);

  always_comb begin
    status = 32'h0;
    status[`CCS_ST_RATE] = s_q.rate;
    status[`CCS_ST_FAULT] = s_q.fault;
    status[`CCS_ST_CALIB] = (s_q.cal == CCS_CAL);
    // Quality flags are hidden on the plain data connection.
    if (s_q.ctrl[`CCS_CTRL_CALCONN]) begin
      status[`CCS_ST_GLOW] = s_q.glow;
      status[`CCS_ST_BLOW] = s_q.blow;
      status[`CCS_ST_GHIGH] = s_q.ghigh;
      status[`CCS_ST_BHIGH] = s_q.bhigh;
      status[`CCS_ST_OK] = s_q.ok;
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    // Bus slave: address and data may arrive in either order.
    if (s_axi_awvalid && !s_q.awr_q) begin
      s_d.awr_q = 1'b1;
      s_d.awaddr_q = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_q.wr_q) begin
      s_d.wr_q = 1'b1;
      s_d.wdata_q = s_axi_wdata;
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    if (s_q.awr_q && s_q.wr_q && !s_q.bvalid) begin
      s_d.awr_q = 1'b0;
      s_d.wr_q = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = `CCS_RESP_OKAY;
      case (s_q.awaddr_q)
        `CCS_ADDR_CTRL: begin
          if (s_axi_wstrb[0]) begin
            s_d.ctrl = s_q.wdata_q[3:0];
          end
        end
        `CCS_ADDR_LIMIT: begin
          s_d.limit = s_q.wdata_q;
        end
        `CCS_ADDR_STATUS, `CCS_ADDR_DATA, `CCS_ADDR_STAMP,
        `CCS_ADDR_SAMPLE: begin
        end
        default: s_d.bresp = `CCS_RESP_SLVERR;
      endcase
    end
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !s_q.rvalid && !s_q.arvalid_seen) begin
      s_d.arvalid_seen = 1'b1;
      s_d.rvalid = 1'b1;
      s_d.rresp = `CCS_RESP_OKAY;
      case (s_axi_araddr)
        `CCS_ADDR_CTRL: s_d.rdata = {28'h0, s_q.ctrl};
        `CCS_ADDR_LIMIT: s_d.rdata = s_q.limit;
        `CCS_ADDR_STATUS: s_d.rdata = status;
        `CCS_ADDR_DATA: s_d.rdata = s_q.value;
        `CCS_ADDR_STAMP: s_d.rdata = {17'h0, s_q.scan_stamp};
        `CCS_ADDR_SAMPLE: s_d.rdata = s_q.sample;
        default: begin
          s_d.rdata = 32'h0;
          s_d.rresp = `CCS_RESP_SLVERR;
        end
      endcase
    end else begin
      s_d.arvalid_seen = 1'b0;
    end

    // Millisecond tick; the counter wraps naturally at 15 bits.
    if (s_q.tick_cnt == 15'(TICK_CYC - 1)) begin
      s_d.tick_cnt = 15'h0;
      s_d.stamp = s_q.stamp + 15'h1;
    end else begin
      s_d.tick_cnt = s_q.tick_cnt + 15'h1;
    end

    if (scan_strobe) begin
      s_d.scan_stamp = s_q.stamp;
      s_d.value = scan_value;
      s_d.sample = scan_sample;
      // The first scan has no predecessor, so it compares with itself.
      s_d.prev_sample = s_q.have_prev ? s_q.sample : scan_sample;
      s_d.have_prev = 1'b1;
    end

    // Rate alarm: set wins over the unlatch edge.
    s_d.unl_prev = s_q.ctrl[`CCS_CTRL_UNLATCH];
    if (s_q.ctrl[`CCS_CTRL_UNLATCH] && !s_q.unl_prev) begin
      s_d.rate = 1'b0;
    end else if (!s_q.ctrl[`CCS_CTRL_LATCH]) begin
      s_d.rate = 1'b0;
    end
    if (s_q.ctrl[`CCS_CTRL_ENABLE] && s_q.have_prev &&
        diff > s_q.limit) begin
      s_d.rate = 1'b1;
    end
    if (!s_q.ctrl[`CCS_CTRL_ENABLE]) begin
      s_d.rate = 1'b0;
    end

    // Calibration sequence.
    case (s_q.cal)
      CCS_IDLE, CCS_DONE: begin
        if (cal_start) begin
          s_d.cal = CCS_CAL;
          s_d.glow = 1'b0;
          s_d.blow = 1'b0;
          s_d.ghigh = 1'b0;
          s_d.bhigh = 1'b0;
          s_d.ok = 1'b0;
        end
      end
      CCS_CAL: begin
        if (low_ref_sampled) begin
          s_d.glow = low_ref_good;
          s_d.blow = !low_ref_good;
        end
        if (high_ref_sampled) begin
          s_d.ghigh = high_ref_good;
          s_d.bhigh = !high_ref_good;
        end
        if (cal_abort) begin
          s_d.cal = CCS_IDLE;
          if (s_q.blow || s_q.bhigh) begin
            s_d.fault = 1'b1;
          end
        end else if (cal_finish) begin
          if (s_q.glow && s_q.ghigh && !s_q.blow && !s_q.bhigh) begin
            s_d.cal = CCS_DONE;
            s_d.ok = 1'b1;
            s_d.fault = 1'b0;
          end else begin
            s_d.cal = CCS_IDLE;
            s_d.fault = 1'b1;
          end
        end
      end
      default: s_d.cal = CCS_IDLE;
    endcase
    // Success persists only while the connection stays open.
    if (!conn_open && s_q.cal != CCS_CAL) begin
      s_d.ok = 1'b0;
    end
    if (cal_data_applied && s_q.cal != CCS_CAL) begin
      s_d.ok = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign s_axi_awready = !s_q.awr_q;
  assign s_axi_wready = !s_q.wr_q;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_arready = !s_q.rvalid && !s_q.arvalid_seen;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
  assign rate_of_change_alarm = s_q.rate;
  assign calibration_fault_flag = s_q.fault;
  assign calibrating = (s_q.cal == CCS_CAL);
  assign calibration_done_ok = s_q.ctrl[`CCS_CTRL_CALCONN] & s_q.ok;
  assign scan_millisecond_stamp = s_q.scan_stamp;

endmodule // ccs_top

// file: pkg/ccs_map.svh
`ifndef CCS_MAP_SVH
`define CCS_MAP_SVH
// Operation
// - Rate alarm sets when sample change per interval exceeds the rate limit.
// - With latching on, rate alarm holds until an unlatch rising edge.
// - Calibration fault sets when the last calibration attempt failed.
// - Calibration fault is zero after power-up reset.
// - Calibrating flag is one while calibrating, zero otherwise.
// - Good low reference sets once a valid low reference is sampled.
// - Bad low reference sets when low reference is invalid; blocks success.
// - Abort with bad low reference sets fault until later success.
// - Good high reference sets once a valid high reference is sampled.
// - Bad high reference sets when high reference is invalid; blocks success.
// - Abort with bad high reference sets fault until later success.
// - Reference and success flags read zero unless calibration connection selected.
// - Success sets when calibration completes and calibrating state is left.
// - Success stays set while the controller connection remains open.
// - Success also reads one when stored calibration data is applied.
// - Channel value is a signed float in engineering units.
// - Free-running 15-bit millisecond stamp counter.
// - Each scan captures the stamp alongside the scanned data.

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define CCS_ADDR_CTRL 8'h00
`define CCS_ADDR_LIMIT 8'h04
`define CCS_ADDR_STATUS 8'h08
`define CCS_ADDR_DATA 8'h0c
`define CCS_ADDR_STAMP 8'h10
`define CCS_ADDR_SAMPLE 8'h14
`define CCS_CTRL_LATCH 0
`define CCS_CTRL_UNLATCH 1
`define CCS_CTRL_CALCONN 2
`define CCS_CTRL_ENABLE 3
`define CCS_ST_RATE 0
`define CCS_ST_FAULT 1
`define CCS_ST_CALIB 2
`define CCS_ST_GLOW 3
`define CCS_ST_BLOW 4
`define CCS_ST_GHIGH 5
`define CCS_ST_BHIGH 6
`define CCS_ST_OK 7
`define CCS_RESP_OKAY 2'b00
`define CCS_RESP_SLVERR 2'b10
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CCS_CLK_HZ 25000000
`define CCS_TICK_MS 1
`define CCS_TICK_CYC (`CCS_CLK_HZ / 1000 * `CCS_TICK_MS)
`define CCS_STAMP_W 15
`endif

// file: pkg/ccs_pkg.sv
package ccs_pkg;
  typedef enum logic [1:0] {
    CCS_IDLE,
    CCS_CAL,
    CCS_DONE
  } ccs_cal_t;

  typedef struct packed {
    logic awr_q;
    logic [7:0] awaddr_q;
    logic wr_q;
    logic [31:0] wdata_q;
    logic bvalid;
    logic [1:0] bresp;
    logic arvalid_seen;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [3:0] ctrl;
    logic [31:0] limit;
    logic unl_prev;
    logic [14:0] tick_cnt;
    logic [14:0] stamp;
    logic [14:0] scan_stamp;
    logic [31:0] sample;
    logic [31:0] prev_sample;
    logic [31:0] value;
    logic have_prev;
    logic rate;
    logic fault;
    ccs_cal_t cal;
    logic glow;
    logic blow;
    logic ghigh;
    logic bhigh;
    logic ok;
  } ccs_state_t;
endpackage

// file: verif/ccs_props.sv
`timescale 1ns/1ps
// ----
// Checker on the top ports
// ----
module ccs_props (
  input wire logic clk,
  input wire logic nrst,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic cal_start,
  input wire logic cal_abort,
  input wire logic cal_finish,
  input wire logic conn_open,
  input wire logic cal_data_applied,
  input wire logic scan_strobe,
  input wire logic calibrating,
  input wire logic calibration_fault_flag,
  input wire logic calibration_done_ok,
  input wire logic [14:0] scan_millisecond_stamp
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_rst; $rose(nrst) |-> !calibration_fault_flag; endproperty
  a_rst: assert property (p_rst) else $error("fault set at reset");
  property p_con; cal_start |=> calibrating; endproperty
  a_con: assert property (p_con) else $error("no calibrating");
  property p_coff; cal_abort || cal_finish |=> !calibrating; endproperty
  a_coff: assert property (p_coff) else $error("still calib");
  property p_stm; !scan_strobe |=> $stable(scan_millisecond_stamp);
  endproperty
  a_stm: assert property (p_stm) else $error("stamp off scan");
  property p_flt;
    !cal_abort && !cal_finish |=> $stable(calibration_fault_flag);
  endproperty
  a_flt: assert property (p_flt) else $error("fault moved");
  property p_ok;
    !conn_open && !cal_data_applied |=> !calibration_done_ok;
  endproperty
  a_ok: assert property (p_ok) else $error("ok without link");
  property p_b; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
  a_b: assert property (p_b) else $error("bvalid dropped");
  property p_r; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_r: assert property (p_r) else $error("no read answer");
endmodule // ccs_props
bind ccs_top ccs_props PROPS (.*);

// file: verif/ccs_front.sv
`timescale 1ns/1ps
// ----
// Channel scan source
// ----
// Between scans the lines toggle each cycle between the inverted and the true last value.
module ccs_front (
  input wire logic clk,
  input wire logic go,
  input wire logic [31:0] smp,
  output logic scan_strobe,
  output logic [31:0] scan_sample,
  output logic [31:0] scan_value
);
  initial scan_strobe = 1'h0;
  always @(posedge clk) begin
    scan_strobe <= go;
    scan_sample <= go ? smp : ~scan_sample;
    scan_value <= go ? smp ^ 32'h5a5a0000 : ~scan_value;
  end
endmodule // ccs_front

// file: verif/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic clk = 1'h0, nrst = 1'h0, go = 1'h0, s_axi_awvalid = 1'h0;
  logic s_axi_wvalid = 1'h0, s_axi_bready = 1'h1, s_axi_arvalid = 1'h0;
  logic s_axi_rready = 1'h1, cal_start = 1'h0, cal_abort = 1'h0;
  logic cal_finish = 1'h0, low_ref_sampled = 1'h0, low_ref_good = 1'h0;
  logic high_ref_sampled = 1'h0, high_ref_good = 1'h0, conn_open = 1'h1;
  logic cal_data_applied = 1'h0, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, rate_of_change_alarm, calibrating;
  logic calibration_fault_flag, calibration_done_ok, scan_strobe;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0, smp = 32'h0, v;
  logic [31:0] s_axi_rdata, scan_sample, scan_value;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [14:0] scan_millisecond_stamp, s1;
  logic [33:0] exp_q[$];
  int error_cnt = 0, num_checks = 0, seed = 58769;
  // Tick every cycle so the stamp wraps within the run.
  ccs_top #(.TICK_CYC(1)) DUT (.*);
  ccs_front FRONT (.*);
  always #20 clk = ~clk;
  task automatic chk(string n, logic [33:0] s, logic [33:0] e);
    num_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    chk("bresp", s_axi_bresp, r);
  endtask
  task automatic rd(logic [7:0] a, logic [33:0] e);
    exp_q.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
  endtask
  always @(posedge clk) if (s_axi_rvalid && exp_q.size() > 0)
    chk("read", {s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
  task automatic scan(logic [31:0] d, logic e);
    go <= 1'h1;
    smp <= d;
    @(posedge clk);
    go <= 1'h0;
    repeat (5) @(posedge clk);
    chk("rate", rate_of_change_alarm, e);
  endtask
  task automatic cal(logic lg, logic hg, logic fin, logic f0);
    cal_start <= 1'h1;
    @(posedge clk);
    cal_start <= 1'h0;
    low_ref_sampled <= 1'h1;
    low_ref_good <= lg;
    high_ref_sampled <= 1'h1;
    high_ref_good <= hg;
    @(posedge clk);
    low_ref_sampled <= 1'h0;
    high_ref_sampled <= 1'h0;
    @(posedge clk);
    chk("calib", calibrating, 1'h1);
    rd(8'h08, {26'h0, ~hg, hg, ~lg, lg, 1'h1, f0, 1'h0});
    cal_finish <= fin;
    cal_abort <= ~fin;
    @(posedge clk);
    cal_finish <= 1'h0;
    cal_abort <= 1'h0;
    repeat (3) @(posedge clk);
    chk("fault", calibration_fault_flag, !(lg && hg));
    chk("ok", calibration_done_ok, lg && hg);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clk);
    error_cnt++;
    test_done;
  end
  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'h1;
    @(posedge clk);
    rd(8'h08, 34'h0);
    wr(8'h20, 32'h1, 2'h2);
    rd(8'h20, {2'h2, 32'h0});
    wr(8'h04, 32'ha, 2'h0);
    wr(8'h00, 32'h8, 2'h0);
    scan(32'd100, 1'h0);
    scan(32'd120, 1'h1);
    scan(32'd130, 1'h0);
    wr(8'h00, 32'h9, 2'h0);
    scan(32'd200, 1'h1);
    scan(32'd201, 1'h1);
    wr(8'h00, 32'hb, 2'h0);
    repeat (3) @(posedge clk);
    chk("unlatch", rate_of_change_alarm, 1'h0);
    $display("done rate");
    wr(8'h00, 32'h0, 2'h0);
    v = $random(seed);
    scan(v, 1'h0);
    rd(8'h0c, {2'h0, v ^ 32'h5a5a0000});
    wr(8'h00, 32'h4, 2'h0);
    cal(1'h0, 1'h1, 1'h0, 1'h0);
    cal(1'h1, 1'h0, 1'h1, 1'h1);
    cal(1'h1, 1'h1, 1'h1, 1'h1);
    conn_open <= 1'h0;
    repeat (3) @(posedge clk);
    chk("ok", calibration_done_ok, 1'h0);
    conn_open <= 1'h1;
    cal_data_applied <= 1'h1;
    wr(8'h00, 32'h0, 2'h0);
    rd(8'h08, 34'h0);
    wr(8'h00, 32'h4, 2'h0);
    repeat (2) @(posedge clk);
    chk("ok", calibration_done_ok, 1'h1);
    $display("done cal");
    scan(32'h0, 1'h0);
    s1 = scan_millisecond_stamp;
    repeat (34) @(posedge clk);
    scan(32'h0, 1'h0);
    chk("gap", 15'(scan_millisecond_stamp - s1), 15'd40);
    s1 = scan_millisecond_stamp;
    repeat (32769) @(posedge clk);
    scan(32'h0, 1'h0);
    chk("wrap", 15'(scan_millisecond_stamp - s1), 15'd7);
    $display("done stamp");
    test_done;
  end
endmodule // testbench
